// File: hw/wsp_pkg.sv
// What the document requires of this block and of the master
// R01: slave only, never drives clock or conditions
// R02: transfers accepted only inside communication window
// R03: indicator held low while window open
// R04: window closes if no transfer before timeout
// R05: pointer preset from start setting on window entry
// R06: indicator is open-drain, pulled low only
// R07: master makes clock, START and STOP
// R08: master starts only on idle bus
// R09: data change with clock high is condition
// R10: bus idle when clock and data high
// R11: START is data falling, clock high
// R12: STOP is data rising, clock high
// R13: STOP closes window at once
// R14: one bit per clock, sampled high
// R15: device pulls data low on ack pulse
// R16: master supplies ninth clock per byte
// R17: no acknowledge outside the window
// R18: first byte: 7-bit address plus direction
// R19: respond only to fixed bus address
// R20: write: first byte pointer, rest data
// R21: pointer advances after each data byte
// R22: out-of-map write is discarded
// R23: master requests window by 10ms low pulse
// R24: address mismatch: no ack, ignore until START
// R25: master waits for clock really high
package wsp_pkg;

  // window and request times, cycle counts from the core clock rate
  localparam int CLK_HZ = 25_000_000;
  localparam int WIN_MS = 2;
  localparam int HS_LOW_MS = 10;
  localparam int WIN_CYC = WIN_MS * (CLK_HZ / 1000);
  localparam int HS_CYC = HS_LOW_MS * (CLK_HZ / 1000);

  // bus address and byte framing
  localparam logic [6:0] BUS_ADDR = 7'h44;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int MAP_WORDS_DEF = 128;

  // link side states
  typedef enum logic [2:0] {
    LS_IDLE = 3'b000,
    LS_CTRL = 3'b001,
    LS_PTR = 3'b010,
    LS_DATA = 3'b011,
    LS_READ = 3'b100,
    LS_IGNORE = 3'b101
  } wsp_lnk_st_t;

  // window states
  typedef enum logic {
    WS_SHUT = 1'b0,
    WS_OPEN = 1'b1
  } wsp_win_st_t;

  // one received byte handed from the link to the core
  typedef struct packed {
    logic is_ptr;
    logic [7:0] data;
  } wsp_byte_t;

  // write strobe towards the settings store
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } wsp_wr_t;

endpackage : wsp_pkg

// File: hw/wsp_sync.sv
// two flip-flop level synchroniser, only the second stage leaves
module wsp_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule : wsp_sync

// File: hw/wsp_evt_rx.sv
// toggle-to-pulse receiver for events from the other clock domain
module wsp_evt_rx #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] tog_i,
  output logic [W-1:0] pulse_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;

  // edge detect looks only at the settled stages
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= tog_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // one pulse per toggle, each bit independent
  assign pulse_o = sync_reg ^ last_reg;

endmodule : wsp_evt_rx

// File: hw/wsp_port.sv
module wsp_port
  import wsp_pkg::*;
#(
  parameter int WIN_CYCLES = WIN_CYC,
  parameter int HS_CYCLES = HS_CYC,
  parameter int MAP_WORDS = MAP_WORDS_DEF
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic rdy_i,
  output logic rdy_o,
  output logic rdy_oe_o,
  input wire logic conv_done_i,
  input wire logic win_unlim_i,
  input wire logic [7:0] start_ptr_i,
  output logic conv_run_o,
  output logic [8:0] ptr_o,
  output wsp_wr_t wr_o
);

  localparam int WCW = $clog2(WIN_CYCLES + 1);
  localparam int HCW = $clog2(HS_CYCLES + 1);


  // link domain: runs on link_clk_i and oversamples the bus pins

  logic [1:0] bus_s;
  logic win_s;
  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_done;
  logic ack_ok;
  wsp_lnk_st_t lst_reg;
  wsp_lnk_st_t lnxt_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic ack_ph_reg;
  logic [2:0] tog_reg;
  wsp_byte_t lbyte_reg;

  // pins pass two flops inverted, so reset reads as an idle bus
  wsp_sync #(.W(2)) u_bus_sync (
    .clock_i(link_clk_i),
    .nrst_i(nrst_i),
    .d_i({~scl_i, ~sda_i}),
    .q_o(bus_s)
  );

  // window level from the core domain
  wsp_sync #(.W(1)) u_win_sync (
    .clock_i(link_clk_i),
    .nrst_i(nrst_i),
    .d_i(rdy_oe_o),
    .q_o(win_s)
  );

  assign scl_s = ~bus_s[1];
  assign sda_s = ~bus_s[0];

  // previous synchronised levels, for edge detection
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // bit timing follows the master clock only; the device never stretches
  assign scl_rise = scl_s & ~scl_d_reg; // R14 R25
  assign scl_fall = ~scl_s & scl_d_reg;
  // data moving while clock stays high is a condition, not a bit
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s; // R09 R11
  assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s; // R09 R12
  assign byte_done = scl_fall & ~ack_ph_reg & (bit_cnt_reg == BITS_PER_BYTE);

  // acknowledge only while the window is open and the address fits
  always_comb begin
    ack_ok = 1'b0;
    if (win_s) begin // R02 R17
      case (lst_reg)
        LS_CTRL: ack_ok = (shift_reg[7:1] == BUS_ADDR); // R18 R19
        LS_PTR: ack_ok = 1'b1;
        LS_DATA: ack_ok = 1'b1;
        default: ack_ok = 1'b0;
      endcase
    end
  end

  // byte framing state machine
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lst_reg <= LS_IDLE;
      lnxt_reg <= LS_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_ph_reg <= 1'b0;
    end else if (start_cond) begin
      // a start is honoured in any state, also as a repeated start
      lst_reg <= LS_CTRL; // R11
      bit_cnt_reg <= 4'h0;
      ack_ph_reg <= 1'b0;
    end else if (stop_cond) begin
      lst_reg <= LS_IDLE; // R10 R12
      bit_cnt_reg <= 4'h0;
      ack_ph_reg <= 1'b0;
    end else if (scl_rise && !ack_ph_reg && bit_cnt_reg != BITS_PER_BYTE) begin
      case (lst_reg)
        LS_CTRL, LS_PTR, LS_DATA: begin
          shift_reg <= {shift_reg[6:0], sda_s}; // R14
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        default: begin
          bit_cnt_reg <= bit_cnt_reg;
        end
      endcase
    end else if (scl_fall && ack_ph_reg) begin
      // end of the ninth pulse, next byte begins
      ack_ph_reg <= 1'b0; // R16
      lst_reg <= lnxt_reg;
      bit_cnt_reg <= 4'h0;
    end else if (byte_done) begin
      if (!ack_ok) begin
        lst_reg <= LS_IGNORE; // R17 R24
      end else begin
        ack_ph_reg <= 1'b1;
        case (lst_reg)
          LS_CTRL: lnxt_reg <= shift_reg[0] ? LS_READ : LS_PTR; // R20
          LS_PTR: lnxt_reg <= LS_DATA; // R20
          default: lnxt_reg <= LS_DATA;
        endcase
      end
    end
  end

  // data pin: only ever pulled low, and only for the ack pulse
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_oe_o <= 1'b0;
    end else if (start_cond || stop_cond) begin
      sda_oe_o <= 1'b0; // R01
    end else if (byte_done) begin
      sda_oe_o <= ack_ok; // R15
    end else if (scl_fall && ack_ph_reg) begin
      sda_oe_o <= 1'b0; // R15
    end
  end

  // constant low level; the enable alone drives the pin
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // events to the core: start, stop, byte; byte stays held until next one
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tog_reg <= 3'h0;
      lbyte_reg <= '0;
    end else begin
      if (start_cond) begin
        tog_reg[0] <= ~tog_reg[0];
      end
      if (stop_cond) begin
        tog_reg[1] <= ~tog_reg[1];
      end
      if (byte_done && ack_ok && lst_reg != LS_CTRL) begin
        lbyte_reg <= '{is_ptr: (lst_reg == LS_PTR), data: shift_reg}; // R20
        tog_reg[2] <= ~tog_reg[2];
      end
    end
  end


  // core domain: window timing, pointer and write port

  logic [2:0] evt;
  logic evt_start;
  logic evt_stop;
  logic evt_byte;
  logic rdy_s;
  logic hs_full;
  logic open_req;
  wsp_win_st_t wst_reg;
  logic started_reg;
  logic [WCW-1:0] win_cnt_reg;
  logic [HCW-1:0] hs_cnt_reg;
  logic hs_seen_reg;

  // byte contents are stable for many core cycles after the toggle
  wsp_evt_rx #(.W(3)) u_evt_rx (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .tog_i(tog_reg),
    .pulse_o(evt)
  );

  // indicator pin level as seen from outside
  wsp_sync #(.W(1)) u_rdy_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .d_i(rdy_i),
    .q_o(rdy_s)
  );

  assign evt_start = evt[0];
  assign evt_stop = evt[1];
  assign evt_byte = evt[2];

  // master request: line held low long enough, then released
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hs_cnt_reg <= '0;
      hs_seen_reg <= 1'b0;
    end else if (rdy_oe_o || rdy_s) begin
      // our own drive must not count as a request
      hs_cnt_reg <= '0;
      hs_seen_reg <= 1'b0;
    end else if (hs_cnt_reg == HCW'(HS_CYCLES - 1)) begin
      hs_seen_reg <= 1'b1; // R23
    end else begin
      hs_cnt_reg <= hs_cnt_reg + HCW'(1);
    end
  end

  // seen flag survives the first high sample, which opens the window
  assign hs_full = hs_seen_reg;
  assign open_req = conv_done_i | (hs_full & rdy_s & ~rdy_oe_o); // R23

  // window state, indicator drive and conversion enable
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wst_reg <= WS_SHUT;
      started_reg <= 1'b0;
      win_cnt_reg <= '0;
      rdy_oe_o <= 1'b0;
      conv_run_o <= 1'b1;
    end else begin
      case (wst_reg)
        WS_SHUT: begin
          if (open_req) begin
            wst_reg <= WS_OPEN;
            started_reg <= 1'b0;
            win_cnt_reg <= '0;
            rdy_oe_o <= 1'b1; // R03 R06 R23
            conv_run_o <= 1'b0;
          end
        end
        WS_OPEN: begin
          if (evt_stop) begin
            wst_reg <= WS_SHUT; // R13
            rdy_oe_o <= 1'b0;
            conv_run_o <= 1'b1;
          end else if (evt_start) begin
            started_reg <= 1'b1;
          end else if (!started_reg && !win_unlim_i) begin
            if (win_cnt_reg == WCW'(WIN_CYCLES - 1)) begin
              wst_reg <= WS_SHUT; // R04
              rdy_oe_o <= 1'b0;
              conv_run_o <= 1'b1;
            end else begin
              win_cnt_reg <= win_cnt_reg + WCW'(1); // R03
            end
          end
        end
        default: begin
          wst_reg <= WS_SHUT;
          rdy_oe_o <= 1'b0;
          conv_run_o <= 1'b1;
        end
      endcase
    end
  end

  // indicator level is always low; enable decides pull or release
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdy_o <= 1'b0;
    end else begin
      rdy_o <= 1'b0; // R06
    end
  end

  // pointer: preset on entry, set by pointer byte, bumped per data byte
  // ninth bit parks the pointer past the map so it never wraps back in
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_o <= 9'h000;
    end else if (wst_reg == WS_SHUT && open_req) begin
      ptr_o <= {1'b0, start_ptr_i}; // R05
    end else if (evt_byte && wst_reg == WS_OPEN) begin
      if (lbyte_reg.is_ptr) begin
        ptr_o <= {1'b0, lbyte_reg.data}; // R20
      end else if (!ptr_o[8]) begin
        ptr_o <= ptr_o + 9'h001; // R21
      end
    end
  end

  // write strobe, suppressed for addresses beyond the map
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_o <= '0;
    end else begin
      wr_o.en <= evt_byte && wst_reg == WS_OPEN && !lbyte_reg.is_ptr
                 && (32'(ptr_o) < 32'(MAP_WORDS)); // R02 R22
      wr_o.addr <= ptr_o[7:0];
      wr_o.data <= lbyte_reg.data;
    end
  end

endmodule : wsp_port

// File: verification/wsp_port_properties.sv
module wsp_port_chk
  import wsp_pkg::*;
#(
  parameter int MAP_WORDS = MAP_WORDS_DEF
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic rdy_o,
  input wire logic rdy_oe_o,
  input wire logic conv_done_i,
  input wire logic [7:0] start_ptr_i,
  input wire logic conv_run_o,
  input wire logic [8:0] ptr_o,
  input wire wsp_wr_t wr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // open request while shut, then ack start
  sequence s_open;
    conv_done_i && conv_run_o;
  endsequence
  sequence s_ack;
    $rose(sda_oe_o) ##0 !scl_i;
  endsequence
  property p_rdy_low;
    @(posedge clock_i) disable iff (!nrst_i) rdy_o == 1'b0;
  endproperty
  a_rdy_low: assert property (p_rdy_low) else $error("indicator data not low");
  property p_open;
    @(posedge clock_i) disable iff (!nrst_i) s_open |=> rdy_oe_o && !conv_run_o;
  endproperty
  a_open: assert property (p_open) else $error("window did not open");
  property p_preset;
    @(posedge clock_i) disable iff (!nrst_i) s_open |=> ptr_o == {1'b0, $past(start_ptr_i)};
  endproperty
  a_preset: assert property (p_preset) else $error("pointer not preset");
  property p_run_pair;
    @(posedge clock_i) disable iff (!nrst_i) rdy_oe_o != conv_run_o;
  endproperty
  a_run_pair: assert property (p_run_pair) else $error("window and run disagree");
  property p_map;
    @(posedge clock_i) disable iff (!nrst_i) wr_o.en |-> wr_o.addr < MAP_WORDS;
  endproperty
  a_map: assert property (p_map) else $error("write outside map");
  property p_wr_pulse;
    @(posedge clock_i) disable iff (!nrst_i) wr_o.en |=> !wr_o.en;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  // an ack that rises with clock low must then stand for four more link cycles
  property p_ack;
    @(posedge link_clk_i) disable iff (!nrst_i) s_ack |=> sda_oe_o [*4];
  endproperty
  a_ack: assert property (p_ack) else $error("ack badly placed");
  property p_ack_win;
    @(posedge link_clk_i) disable iff (!nrst_i) sda_oe_o |-> rdy_oe_o;
  endproperty
  a_ack_win: assert property (p_ack_win) else $error("ack outside window");
endmodule : wsp_port_chk

bind wsp_port wsp_port_chk #(.MAP_WORDS(MAP_WORDS)) chk_u (
  .clock_i(clock_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
  .sda_oe_o(sda_oe_o), .rdy_o(rdy_o), .rdy_oe_o(rdy_oe_o), .conv_done_i(conv_done_i),
  .start_ptr_i(start_ptr_i), .conv_run_o(conv_run_o), .ptr_o(ptr_o), .wr_o(wr_o)
);

// File: verification/wsp_host_model.sv
module wsp_host_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o,
  output logic rdy_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 400; // quarter bit, keeps clock low well over 4 link cycles
  // bus idle, both lines released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    rdy_low_o = 1'b0;
  end
  // start from idle or as repeated start
  task automatic start();
    sda_low_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q;
  endtask : start
  task automatic stop();
    sda_low_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b0;
    #Q;
  endtask : stop
  // msb first, data changes only with clock low
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_o = !b[i];
      #Q scl_o = 1'b1;
      #(2 * Q) scl_o = 1'b0;
      #Q;
    end
    sda_low_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q ack = sda_i; // high means not acknowledged
    #Q scl_o = 1'b0;
    #Q;
  endtask : send
  task automatic hs(input int ns);
    rdy_low_o = 1'b1;
    #ns rdy_low_o = 1'b0;
  endtask : hs
endmodule : wsp_host_model

// File: verification/windowed_i2c_slave_port_test.sv
module windowed_i2c_slave_port_test;
  import wsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WC = 200;
  localparam int HC = 100;
  logic clock_i, nrst_i, link_clk_i, conv_done_i, win_unlim_i;
  logic [7:0] start_ptr_i, d;
  logic scl, sda_low, rdy_low, sda_oe, rdy_oe, conv_run, ack, sda_lvl, rdy_lvl;
  logic [8:0] ptr;
  wsp_wr_t wr;
  // pull-ups: a line is low only where someone enables a low level
  wire sda_w = !sda_low & (!sda_oe | sda_lvl);
  wire rdy_w = !rdy_low & (!rdy_oe | rdy_lvl);
  int bad_count, check_count, cyc, tn;
  integer seed = 32'h0d8f;
  logic [15:0] exp_q[$];

  wsp_port #(.WIN_CYCLES(WC), .HS_CYCLES(HC), .MAP_WORDS(128)) dut_u (
    .clock_i(clock_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_lvl), .sda_oe_o(sda_oe),
    .rdy_i(rdy_w), .rdy_o(rdy_lvl), .rdy_oe_o(rdy_oe),
    .conv_done_i(conv_done_i), .win_unlim_i(win_unlim_i), .start_ptr_i(start_ptr_i),
    .conv_run_o(conv_run), .ptr_o(ptr), .wr_o(wr)
  );
  wsp_host_model hst_u (.sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low), .rdy_low_o(rdy_low));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  // link clock, phase unrelated to the core
  initial begin
    link_clk_i = 1'b0;
    #13;
    forever #40 link_clk_i = ~link_clk_i;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask : cy
  task automatic tdone();
    $display("test %0d done", tn);
    tn++;
  endtask : tdone
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // store writes matched against the oldest note, sampled mid-cycle
  always @(negedge clock_i) begin
    if (wr.en === 1'b1) begin
      if (exp_q.size() == 0) chk("wr_extra", 16'h1, 16'h0);
      else chk("wr", {wr.addr, wr.data}, exp_q.pop_front());
    end
  end
  // hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 12000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    nrst_i = 1'b0;
    conv_done_i = 1'b0;
    win_unlim_i = 1'b0;
    start_ptr_i = 8'h00;
    cy(12);
    nrst_i = 1'b1;
    cy(3);
    chk("run", 16'(conv_run), 16'h1);
    chk("rdy_oe", 16'(rdy_oe), 16'h0);
    chk("sda_lvl", 16'(sda_lvl), 16'h0);
    tdone();
    // timed window, idle bus, must lapse
    start_ptr_i = 8'($random(seed));
    conv_done_i = 1'b1;
    cy(1);
    conv_done_i = 1'b0;
    cy(1);
    chk("rdy_line", 16'(rdy_w), 16'h0);
    chk("ptr", 16'(ptr), {8'h00, start_ptr_i});
    chk("run_off", 16'(conv_run), 16'h0);
    cy(WC - 5);
    chk("still_open", 16'(rdy_oe), 16'h1);
    cy(10);
    chk("rdy_oe", 16'(rdy_oe), 16'h0);
    chk("run", 16'(conv_run), 16'h1);
    tdone();
    // control byte while shut gets no ack
    hst_u.start();
    hst_u.send(8'h88, ack);
    chk("ack_shut", 16'(ack), 16'h1);
    hst_u.stop();
    tdone();
    // handshake opens an unlimited window
    win_unlim_i = 1'b1;
    start_ptr_i = 8'h7e;
    hst_u.hs((HC + 10) * 40);
    for (int i = 0; i < 30 && rdy_oe !== 1'b1; i++) cy(1);
    chk("rdy_oe", 16'(rdy_oe), 16'h1);
    chk("ptr", 16'(ptr), 16'h007e);
    cy(WC + 20);
    chk("rdy_line", 16'(rdy_w), 16'h0);
    tdone();
    // foreign address ignored, then a write across the map end
    // timed window now: the first start must hold it open until stop
    win_unlim_i = 1'b0;
    hst_u.start();
    hst_u.send(8'h8a, ack);
    chk("ack_miss", 16'(ack), 16'h1);
    hst_u.send(8'h00, ack);
    chk("ack_ign", 16'(ack), 16'h1);
    hst_u.start();
    hst_u.send(8'h88, ack);
    chk("ack_ctl", 16'(ack), 16'h0);
    hst_u.send(8'h7e, ack);
    chk("ack_ptr", 16'(ack), 16'h0);
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      if (i < 2) exp_q.push_back({8'h7e + 8'(i), d});
      hst_u.send(d, ack);
      chk("ack_data", 16'(ack), 16'h0);
    end
    chk("ptr", 16'(ptr), 16'h0081);
    chk("win_held", 16'(rdy_oe), 16'h1);
    hst_u.stop();
    cy(10);
    chk("rdy_oe", 16'(rdy_oe), 16'h0);
    chk("left", 16'(exp_q.size()), 16'h0);
    tdone();
    tally_and_finish();
  end
endmodule : windowed_i2c_slave_port_test
